// ### include/tcw_pkg.sv
// constants and mode codes of the 8-bit compare timer
// assumes one 50 MHz clock and a 32-bit Avalon-MM port
//
// Functional notes
// R01: a force strobe acts as an output-only match outside fast pwm.
// R02: a counter write blocks compare matches at the next tick.
// R03: output select is unbuffered; a new value acts at the next match.
// R04: compare output states clear at reset.
// R05: nonzero select overrides the port value; the port keeps direction.
// R06: output states survive mode changes.
// R07: select zero leaves the output state alone at a match.
// R08: normal mode counts up only, wrapping ff to 00.
// R09: normal mode sets overflow as the count becomes zero.
// R10: clear-on-match mode clears the counter at compare a.
// R11: compare a is unbuffered; a value below the count waits a wrap.
// R12: clear-on-match sets the match a flag at each top.
// R13: clear-on-match, select one toggles output a at each match.
// R14: clear-on-match sets overflow passing ff to 00.
// R15: fast pwm is mode 3, top ff, or mode 7, top compare a.
// R16: fast pwm counts to top, then clears on the next tick.
// R17: fast pwm select two clears at match, sets at bottom; three inverts.
// R18: fast pwm select one toggles output a only with mode msb.
// R19: fast pwm sets overflow at each top.
// R20: compare at bottom gives one-tick spikes; at max a constant level.
// R21: fast pwm compare writes are buffered until period end.
// R22: a match sets its flag at the tick; ack or write-one clears.
// R23: a counter write beats a clear or count in the same cycle.
// R24: in pwm the buffer moves to the active compare at top.
// R25: clock select zero stops the counter; it stays readable and writable.
// R26: force strobes last one cycle and read back as zero.
// R27: force strobes are ignored in fast pwm.
`default_nettype none

package tcw_pkg;

   // ==========================================================
   // register map, byte addresses
   localparam logic [4:0] TCW_OFS_CTRL_A = 5'h00;
   localparam logic [4:0] TCW_OFS_CTRL_B = 5'h04;
   localparam logic [4:0] TCW_OFS_COUNT = 5'h08;
   localparam logic [4:0] TCW_OFS_CMP_A = 5'h0c;
   localparam logic [4:0] TCW_OFS_CMP_B = 5'h10;
   localparam logic [4:0] TCW_OFS_FLAGS = 5'h14;

   // ==========================================================
   // field positions
   localparam int TCW_SEL_A_LSB = 6;
   localparam int TCW_SEL_B_LSB = 4;
   localparam int TCW_MODE_LO_LSB = 0;
   localparam int TCW_FORCE_A_BIT = 7;
   localparam int TCW_FORCE_B_BIT = 6;
   localparam int TCW_MODE_MSB_BIT = 3;
   localparam int TCW_CS_LSB = 0;
   localparam int TCW_OVF_BIT = 0;
   localparam int TCW_MATCH_A_BIT = 1;
   localparam int TCW_MATCH_B_BIT = 2;

   // ==========================================================
   // values
   localparam logic [7:0] TCW_BOTTOM = 8'h00;
   localparam logic [7:0] TCW_MAX = 8'hff;
   localparam logic [7:0] TCW_BYTE_RST = 8'h00;
   localparam logic [1:0] TCW_SEL_OFF = 2'h0;
   localparam logic [1:0] TCW_SEL_TOGGLE = 2'h1;
   localparam logic [1:0] TCW_SEL_CLEAR = 2'h2;
   localparam logic [1:0] TCW_SEL_SET = 2'h3;

   // ==========================================================
   // prescaler taps: all-ones low bits tick
   localparam logic [9:0] TCW_DIV8_MASK = 10'h007;
   localparam logic [9:0] TCW_DIV64_MASK = 10'h03f;
   localparam logic [9:0] TCW_DIV256_MASK = 10'h0ff;
   localparam logic [9:0] TCW_DIV1024_MASK = 10'h3ff;

   typedef enum logic [2:0] {
      TCW_CS_STOP = 3'b000,
      TCW_CS_DIV1 = 3'b001,
      TCW_CS_DIV8 = 3'b010,
      TCW_CS_DIV64 = 3'b011,
      TCW_CS_DIV256 = 3'b100,
      TCW_CS_DIV1024 = 3'b101,
      TCW_CS_EXT_FALL = 3'b110,
      TCW_CS_EXT_RISE = 3'b111
   } tcw_cs_e;

   typedef enum logic [2:0] {
      TCW_WM_NORMAL = 3'b000,
      TCW_WM_CLEAR_ON_MATCH = 3'b010,
      TCW_WM_FAST_MAX = 3'b011,
      TCW_WM_FAST_CMP = 3'b111
   } tcw_mode_e;

endpackage : tcw_pkg

`default_nettype wire

// ### tb/tcw_timer8_props.sv
// port checker for the timer
// assumes a bind onto tcw_timer8, low sync reset
`default_nettype none

module tcw_props (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // register bus
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // flags and outputs
   input wire logic [2:0] flag_ack_i,
   input wire logic [2:0] flags_o,
   input wire logic output_a_o,
   input wire logic output_b_o,
   // pins
   input wire logic port_value_a_i,
   input wire logic pin_direction_bit_a_i,
   input wire logic pin_a_o,
   input wire logic pin_a_oe_o,
   input wire logic pin_direction_bit_b_i,
   input wire logic pin_b_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import tcw_pkg::*;
   logic req;
   logic [2:0] clr;
   assign req = avs_read_i | avs_write_i;
   // flag clears at the accepting edge
   assign clr = flag_ack_i | ({3{avs_write_i && !avs_waitrequest_o
      && avs_address_i == TCW_OFS_FLAGS}} & avs_writedata_i[2:0]);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   // ==========================================================
   // assertions
   a_wait_one: assert property ($rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("wait state wrong");
   a_idle_ready: assert property (!req |-> !avs_waitrequest_o)
      else $error("wait while idle");
   a_rdata_upper: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
      else $error("upper bits set");
   a_force_zero: assert property (avs_read_i && !avs_waitrequest_o
      && avs_address_i == TCW_OFS_CTRL_B |-> avs_readdata_o[7:6] == 2'h0)
      else $error("force reads one");
   a_ovf_sticky: assert property ($fell(flags_o[0]) |-> $past(clr[0]))
      else $error("overflow self-cleared");
   a_match_sticky: assert property ($fell(flags_o[1]) |-> $past(clr[1]))
      else $error("match self-cleared");
   a_oe_follow: assert property (pin_a_oe_o == pin_direction_bit_a_i
      && pin_b_oe_o == pin_direction_bit_b_i)
      else $error("pin enable wrong");
   a_pin_source: assert property (pin_a_o == output_a_o || pin_a_o == port_value_a_i)
      else $error("pin a source wrong");
   a_reset_clear: assert property (@(posedge clk_sys_i) disable iff (1'b0) !rstn_i |=>
      !output_a_o && !output_b_o && flags_o == 3'h0)
      else $error("reset left state set");
   c_match: cover property ($rose(flags_o[1]));
   c_toggle: cover property ($rose(output_a_o));
   c_ovf_clr: cover property ($fell(flags_o[0]));
endmodule : tcw_props

bind tcw_timer8 tcw_props u_props (.clk_sys_i, .rstn_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .flag_ack_i,
   .flags_o, .output_a_o, .output_b_o, .port_value_a_i, .pin_direction_bit_a_i, .pin_a_o,
   .pin_a_oe_o, .pin_direction_bit_b_i, .pin_b_oe_o);

`default_nettype wire

// ### tb/tcw_timer8_tb_top.sv
// self-checking bench for the timer
// assumes the checker file compiled alongside
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end

module tcw_timer8_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import tcw_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [4:0] avs_address_i = 5'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [2:0] flag_ack_i = 3'h0;
   logic pva = 1'b0;
   logic dira = 1'b1;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o, output_a_o, output_b_o, pin_a_o, pin_a_oe_o, pin_b_o, pin_b_oe_o;
   logic [2:0] flags_o;
   logic [7:0] rv;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;

   tcw_timer8 dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .ext_clk_i(1'b0), .flag_ack_i(flag_ack_i),
      .flags_o(flags_o), .output_a_o(output_a_o), .output_b_o(output_b_o),
      .port_value_a_i(pva), .pin_direction_bit_a_i(dira), .pin_a_o(pin_a_o),
      .pin_a_oe_o(pin_a_oe_o), .port_value_b_i(1'b1), .pin_direction_bit_b_i(1'b1),
      .pin_b_o(pin_b_o), .pin_b_oe_o(pin_b_oe_o));

   initial begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   // hang guard
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         wrap_up();
      end
   end

   // ==========================================================
   // helpers
   task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_writedata_i <= {24'h0, d};
      avs_write_i <= w;
      avs_read_i <= !w;
      do @(negedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      @(posedge clk_sys_i);
      rv = avs_readdata_o[7:0];
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : acc

   task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      `CHK(rv, e)
   endtask : chk_rd

   // highs of a, toggles of a and b
   task automatic meas(input int n, output int hi, output int ta, output int tb);
      logic pa, pb;
      hi = 0;
      ta = 0;
      tb = 0;
      @(negedge clk_sys_i);
      pa = output_a_o;
      pb = output_b_o;
      repeat (n) begin
         @(negedge clk_sys_i);
         hi += int'(output_a_o);
         ta += int'(output_a_o != pa);
         tb += int'(output_b_o != pb);
         pa = output_a_o;
         pb = output_b_o;
      end
   endtask : meas

   // ==========================================================
   // scenarios
   task automatic t_reset();
      `CHK({output_a_o, output_b_o, flags_o}, 5'h00)
      for (int i = 0; i < 7; i++) begin
         chk_rd(5'(i * 4), 8'h00);
      end
   endtask : t_reset

   task automatic t_force();
      logic [1:0] sl [5] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h1};
      logic ex [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, TCW_OFS_CTRL_A, {sl[i], 2'h3, 4'h0});
         acc(1'b1, TCW_OFS_CTRL_B, 8'hc0);
         repeat (2) @(negedge clk_sys_i);
         `CHK(output_a_o, ex[i])
      end
      `CHK({output_b_o, pin_a_o, pin_a_oe_o}, 3'h5)
      chk_rd(TCW_OFS_CTRL_B, 8'h00);
      chk_rd(TCW_OFS_FLAGS, 8'h00);
      chk_rd(TCW_OFS_COUNT, 8'h00);
      pva <= 1'b1;
      dira <= 1'b0;
      acc(1'b1, TCW_OFS_CTRL_A, 8'hc3);
      acc(1'b1, TCW_OFS_CTRL_B, 8'hc0);
      repeat (2) @(negedge clk_sys_i);
      `CHK({output_a_o, output_b_o}, 2'h1)
      acc(1'b1, TCW_OFS_CTRL_A, 8'h00);
      @(negedge clk_sys_i);
      `CHK({output_b_o, pin_a_o}, 2'h3)
      `CHK(pin_a_oe_o, 1'b0)
   endtask : t_force

   task automatic t_block();
      acc(1'b1, TCW_OFS_CMP_A, 8'h10);
      acc(1'b1, TCW_OFS_COUNT, 8'h10);
      chk_rd(TCW_OFS_COUNT, 8'h10);
      acc(1'b1, TCW_OFS_CTRL_B, 8'h01);
      repeat (4) @(posedge clk_sys_i);
      acc(1'b1, TCW_OFS_CTRL_B, 8'h00);
      chk_rd(TCW_OFS_FLAGS, 8'h00);
      acc(1'b1, TCW_OFS_COUNT, 8'h0f);
      acc(1'b1, TCW_OFS_CTRL_B, 8'h01);
      repeat (4) @(posedge clk_sys_i);
      acc(1'b1, TCW_OFS_CTRL_B, 8'h00);
      chk_rd(TCW_OFS_FLAGS, 8'h02);
      acc(1'b1, TCW_OFS_FLAGS, 8'h02);
      chk_rd(TCW_OFS_FLAGS, 8'h00);
   endtask : t_block

   task automatic t_normal();
      acc(1'b1, TCW_OFS_COUNT, 8'hfd);
      acc(1'b1, TCW_OFS_CTRL_B, 8'h02);
      repeat (77) @(posedge clk_sys_i);
      acc(1'b1, TCW_OFS_CTRL_B, 8'h00);
      acc(1'b0, TCW_OFS_COUNT, 8'h00);
      `CHK(rv, 8'h07)
      `CHK(flags_o[0], 1'b1)
      flag_ack_i <= 3'h1;
      @(posedge clk_sys_i);
      flag_ack_i <= 3'h0;
      @(negedge clk_sys_i);
      `CHK(flags_o[0], 1'b0)
   endtask : t_normal

   task automatic t_ctc();
      int hi, ta, tb;
      acc(1'b1, TCW_OFS_CMP_A, 8'h03);
      acc(1'b1, TCW_OFS_COUNT, 8'h00);
      acc(1'b1, TCW_OFS_CTRL_A, 8'h42);
      acc(1'b1, TCW_OFS_CTRL_B, 8'h01);
      meas(40, hi, ta, tb);
      `CHK(ta, 10)
      `CHK(flags_o[1], 1'b1)
      acc(1'b1, TCW_OFS_CMP_A, 8'h00);
      repeat (300) @(posedge clk_sys_i);
      meas(20, hi, ta, tb);
      `CHK(ta, 20)
      acc(1'b1, TCW_OFS_CTRL_B, 8'h00);
      acc(1'b1, TCW_OFS_CMP_A, 8'h05);
      acc(1'b1, TCW_OFS_COUNT, 8'h20);
      acc(1'b1, TCW_OFS_FLAGS, 8'h07);
      acc(1'b1, TCW_OFS_CTRL_B, 8'h01);
      repeat (100) @(posedge clk_sys_i);
      `CHK(flags_o, 3'h0)
      repeat (200) @(posedge clk_sys_i);
      `CHK(flags_o[1:0], 2'h3)
      acc(1'b1, TCW_OFS_CTRL_A, 8'hc2);
      repeat (10) @(posedge clk_sys_i);
      `CHK(output_a_o, 1'b1)
      acc(1'b1, TCW_OFS_CTRL_A, 8'h82);
      repeat (10) @(posedge clk_sys_i);
      `CHK(output_a_o, 1'b0)
   endtask : t_ctc

   task automatic t_fast();
      logic [7:0] ca [5] = '{8'h83, 8'hc3, 8'h83, 8'h83, 8'hc3};
      logic [7:0] cv [5] = '{8'h40, 8'h40, 8'h00, 8'hff, 8'hff};
      int he [5] = '{65, 191, 1, 256, 0};
      int hi, ta, tb;
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, TCW_OFS_CTRL_A, ca[i]);
         acc(1'b1, TCW_OFS_CMP_A, cv[i]);
         repeat (300) @(posedge clk_sys_i);
         acc(1'b1, TCW_OFS_FLAGS, 8'h07);
         meas(256, hi, ta, tb);
         `CHK(hi, he[i])
         `CHK(flags_o[0], 1'b1)
      end
      acc(1'b1, TCW_OFS_CTRL_A, 8'h53);
      acc(1'b1, TCW_OFS_CMP_A, 8'h09);
      acc(1'b1, TCW_OFS_CTRL_B, 8'h09);
      repeat (300) @(posedge clk_sys_i);
      meas(40, hi, ta, tb);
      `CHK(ta, 4)
      `CHK(tb, 0)
      acc(1'b1, TCW_OFS_CTRL_B, 8'h01);
      repeat (300) @(posedge clk_sys_i);
      meas(40, hi, ta, tb);
      `CHK(ta, 0)
   endtask : t_fast

   // ==========================================================
   // main sequence and verdict
   task automatic wrap_up();
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (8) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      @(posedge clk_sys_i);
      t_reset();
      t_force();
      t_block();
      t_normal();
      t_ctc();
      t_fast();
      wrap_up();
   end
endmodule : tcw_timer8_tb_top

`default_nettype wire

// ### verilog/tcw_channel.sv
// one compare channel: value, match and output state
// assumes strobes from the timer core on the same clock
`default_nettype none

module tcw_channel #(
   parameter bit PWM_TOGGLE = 1'b1
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // timer core
   input wire logic tick_i,
   input wire logic [7:0] count_i,
   input wire logic fast_pwm_i,
   input wire logic mode_msb_i,
   input wire logic block_i,
   input wire logic period_end_i,
   // software side
   input wire logic [1:0] select_i,
   input wire logic force_i,
   input wire logic cmp_wr_i,
   input wire logic [7:0] cmp_wdata_i,
   // results
   output logic [7:0] cmp_buf_o,
   output logic [7:0] cmp_act_o,
   output logic match_o,
   output logic state_o
);
   import tcw_pkg::*;

   logic hit;
   logic act_nxt;
   logic state_nxt;

   // R02 blocked match
   assign hit = tick_i && (count_i == cmp_act_o) && !block_i;
   assign match_o = hit;

   // ==========================================================
   // compare value
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         cmp_buf_o <= TCW_BYTE_RST;
      end else if (cmp_wr_i) begin
         cmp_buf_o <= cmp_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         cmp_act_o <= TCW_BYTE_RST;
      end else if (!fast_pwm_i) begin
         // R11 direct write
         cmp_act_o <= cmp_wr_i ? cmp_wdata_i : cmp_buf_o;
      end else if (period_end_i) begin
         // R21 R24 load at top
         cmp_act_o <= cmp_buf_o;
      end
   end

   // ==========================================================
   // output state
   always_comb begin
      state_nxt = state_o;
      if (!fast_pwm_i) begin
         // R01 R27 force only here
         if (hit || force_i) begin
            case (select_i)
               // R13 toggle on match
               TCW_SEL_TOGGLE: state_nxt = !state_o;
               TCW_SEL_CLEAR: state_nxt = 1'b0;
               TCW_SEL_SET: state_nxt = 1'b1;
               // R07 no action
               default: state_nxt = state_o;
            endcase
         end
      end else begin
         // R17 bottom wins; R20 constant level at max
         if (select_i[1] && period_end_i) begin
            state_nxt = (select_i == TCW_SEL_CLEAR);
         end else if (select_i[1] && hit) begin
            state_nxt = (select_i == TCW_SEL_SET);
         end else if (select_i == TCW_SEL_TOGGLE && hit) begin
            // R18 toggle only on channel a with msb
            state_nxt = (PWM_TOGGLE && mode_msb_i) ? !state_o : state_o;
         end
      end
   end

   // R04 R06 reset only, never on mode change
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         state_o <= 1'b0;
      end else begin
         state_o <= state_nxt;
      end
   end

endmodule : tcw_channel

`default_nettype wire

// ### verilog/tcw_timer8.sv
// 8-bit timer, two compare channels, Avalon-MM registers
// assumes one clock, low sync reset, a port block around the pins
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`default_nettype none

module tcw_timer8 (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // avalon-mm slave
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // external count source
   input wire logic ext_clk_i,
   // flags and interrupt acknowledge
   input wire logic [2:0] flag_ack_i,
   output logic [2:0] flags_o,
   // compare states
   output logic output_a_o,
   output logic output_b_o,
   // pin a
   input wire logic port_value_a_i,
   input wire logic pin_direction_bit_a_i,
   output logic pin_a_o,
   output logic pin_a_oe_o,
   // pin b
   input wire logic port_value_b_i,
   input wire logic pin_direction_bit_b_i,
   output logic pin_b_o,
   output logic pin_b_oe_o
);
   import tcw_pkg::*;

   // ==========================================================
   // declarations
   logic ack_r;
   logic wr_acc;
   logic rd_cap;
   logic be0;
   logic [7:0] wbyte;
   logic [7:0] rd_byte;

   logic [1:0] select_a_r;
   logic [1:0] select_b_r;
   logic [1:0] mode_lo_r;
   logic mode_msb_r;
   tcw_cs_e clock_select_r;
   logic [7:0] counter_value_r;
   logic [7:0] counter_nxt;
   logic block_r;
   logic [2:0] flags_r;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;

   logic [9:0] presc_r;
   logic ext_s1_r;
   logic ext_s2_r;
   logic ext_s3_r;
   logic ext_lvl_r;
   logic ext_prev_r;
   logic tick;

   tcw_mode_e mode;
   logic fast_pwm;
   logic clear_mode;
   logic [7:0] top;
   logic at_top;
   logic period_end;
   logic wrap_clear;

   logic wr_ctrl_a;
   logic wr_ctrl_b;
   logic wr_count;
   logic wr_cmp_a;
   logic wr_cmp_b;
   logic wr_flags;
   logic force_a;
   logic force_b;
   logic [7:0] cmp_buf_a;
   logic [7:0] cmp_buf_b;
   logic [7:0] cmp_act_a;
   logic [7:0] cmp_act_b;
   logic match_a;
   logic match_b;

   // ==========================================================
   // bus handshake
   // one wait state; readdata captured while waiting
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
   assign wr_acc = avs_write_i && ack_r;
   assign rd_cap = avs_read_i && !ack_r;
   assign be0 = avs_byteenable_i[0];
   assign wbyte = avs_writedata_i[7:0];

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
      end
   end

   // ==========================================================
   // write decode
   always_comb begin
      wr_ctrl_a = 1'b0;
      wr_ctrl_b = 1'b0;
      wr_count = 1'b0;
      wr_cmp_a = 1'b0;
      wr_cmp_b = 1'b0;
      wr_flags = 1'b0;
      if (wr_acc && be0) begin
         if (avs_address_i == TCW_OFS_CTRL_A) begin
            wr_ctrl_a = 1'b1;
         end else if (avs_address_i == TCW_OFS_CTRL_B) begin
            wr_ctrl_b = 1'b1;
         end else if (avs_address_i == TCW_OFS_COUNT) begin
            wr_count = 1'b1;
         end else if (avs_address_i == TCW_OFS_CMP_A) begin
            wr_cmp_a = 1'b1;
         end else if (avs_address_i == TCW_OFS_CMP_B) begin
            wr_cmp_b = 1'b1;
         end else if (avs_address_i == TCW_OFS_FLAGS) begin
            wr_flags = 1'b1;
         end
      end
   end

   // ==========================================================
   // read decode, unmapped reads as zero
   always_comb begin
      rd_byte = TCW_BYTE_RST;
      if (avs_address_i == TCW_OFS_CTRL_A) begin
         rd_byte[TCW_SEL_A_LSB +: 2] = select_a_r;
         rd_byte[TCW_SEL_B_LSB +: 2] = select_b_r;
         rd_byte[TCW_MODE_LO_LSB +: 2] = mode_lo_r;
      end else if (avs_address_i == TCW_OFS_CTRL_B) begin
         // R26 strobes read zero
         rd_byte[TCW_MODE_MSB_BIT] = mode_msb_r;
         rd_byte[TCW_CS_LSB +: 3] = clock_select_r;
      end else if (avs_address_i == TCW_OFS_COUNT) begin
         // R25 readable while stopped
         rd_byte = counter_value_r;
      end else if (avs_address_i == TCW_OFS_CMP_A) begin
         rd_byte = cmp_buf_a;
      end else if (avs_address_i == TCW_OFS_CMP_B) begin
         rd_byte = cmp_buf_b;
      end else if (avs_address_i == TCW_OFS_FLAGS) begin
         rd_byte[TCW_OVF_BIT] = flags_r[TCW_OVF_BIT];
         rd_byte[TCW_MATCH_A_BIT] = flags_r[TCW_MATCH_A_BIT];
         rd_byte[TCW_MATCH_B_BIT] = flags_r[TCW_MATCH_B_BIT];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (rd_cap) begin
         avs_readdata_o <= {24'h00_0000, rd_byte};
      end
   end

   // ==========================================================
   // control registers
   // R03 select is live, no shadow copy
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         select_a_r <= TCW_SEL_OFF;
         select_b_r <= TCW_SEL_OFF;
         mode_lo_r <= 2'h0;
      end else if (wr_ctrl_a) begin
         select_a_r <= wbyte[TCW_SEL_A_LSB +: 2];
         select_b_r <= wbyte[TCW_SEL_B_LSB +: 2];
         mode_lo_r <= wbyte[TCW_MODE_LO_LSB +: 2];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         mode_msb_r <= 1'b0;
         clock_select_r <= TCW_CS_STOP;
      end else if (wr_ctrl_b) begin
         mode_msb_r <= wbyte[TCW_MODE_MSB_BIT];
         clock_select_r <= tcw_cs_e'(wbyte[TCW_CS_LSB +: 3]);
      end
   end

   // R26 R27 one-cycle strobes, dropped in fast pwm
   assign force_a = wr_ctrl_b && wbyte[TCW_FORCE_A_BIT] && !fast_pwm;
   assign force_b = wr_ctrl_b && wbyte[TCW_FORCE_B_BIT] && !fast_pwm;

   // ==========================================================
   // timer clock enable
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         presc_r <= 10'h000;
      end else begin
         presc_r <= presc_r + 10'h001;
      end
   end

   // level moves once stages two and three agree
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
         ext_lvl_r <= 1'b0;
         ext_prev_r <= 1'b0;
      end else begin
         ext_s1_r <= ext_clk_i;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         if (ext_s2_r == ext_s3_r) begin
            ext_lvl_r <= ext_s3_r;
         end
         ext_prev_r <= ext_lvl_r;
      end
   end

   always_comb begin
      case (clock_select_r)
         // R25 stopped
         TCW_CS_STOP: tick = 1'b0;
         TCW_CS_DIV1: tick = 1'b1;
         TCW_CS_DIV8: tick = &(presc_r | ~TCW_DIV8_MASK);
         TCW_CS_DIV64: tick = &(presc_r | ~TCW_DIV64_MASK);
         TCW_CS_DIV256: tick = &(presc_r | ~TCW_DIV256_MASK);
         TCW_CS_DIV1024: tick = &(presc_r | ~TCW_DIV1024_MASK);
         TCW_CS_EXT_FALL: tick = ext_prev_r && !ext_lvl_r;
         TCW_CS_EXT_RISE: tick = !ext_prev_r && ext_lvl_r;
         default: tick = 1'b0;
      endcase
   end

   // ==========================================================
   // mode decode
   assign mode = tcw_mode_e'({mode_msb_r, mode_lo_r});
   // R15 fast pwm modes and their top
   assign fast_pwm = (mode == TCW_WM_FAST_MAX) || (mode == TCW_WM_FAST_CMP);
   assign clear_mode = (mode == TCW_WM_CLEAR_ON_MATCH);
   assign top = (mode == TCW_WM_FAST_CMP) ? cmp_act_a : TCW_MAX;
   assign at_top = (counter_value_r == top);
   assign period_end = tick && fast_pwm && at_top;
   // R10 clear at compare a
   assign wrap_clear = fast_pwm ? at_top : (clear_mode && counter_value_r == cmp_act_a);

   // ==========================================================
   // counter
   always_comb begin
      counter_nxt = counter_value_r;
      if (wr_count) begin
         // R23 cpu write first
         counter_nxt = wbyte;
      end else if (tick) begin
         // R16 clear after top; R08 R11 wrap via 8-bit add
         counter_nxt = wrap_clear ? TCW_BOTTOM : counter_value_r + 8'h01;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         counter_value_r <= TCW_BYTE_RST;
      end else begin
         counter_value_r <= counter_nxt;
      end
   end

   // R02 block until next tick, even stopped
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         block_r <= 1'b0;
      end else if (wr_count) begin
         block_r <= 1'b1;
      end else if (tick) begin
         block_r <= 1'b0;
      end
   end

   // ==========================================================
   // flags
   always_comb begin
      flag_set = 3'h0;
      // R09 R14 zero after max; R19 at top in fast pwm
      flag_set[TCW_OVF_BIT] = tick && (fast_pwm ? at_top : counter_value_r == TCW_MAX);
      // R12 R22 match flags at the tick
      flag_set[TCW_MATCH_A_BIT] = match_a;
      flag_set[TCW_MATCH_B_BIT] = match_b;
      flag_clr = flag_ack_i | (wr_flags ? wbyte[2:0] : 3'h0);
   end

   // R22 set wins over clear
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         flags_r <= 3'h0;
      end else begin
         flags_r <= (flags_r & ~flag_clr) | flag_set;
      end
   end

   assign flags_o = flags_r;

   // ==========================================================
   // compare channels
   tcw_channel #(
      .PWM_TOGGLE(1'b1)
   ) u_chan_a (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .tick_i(tick),
      .count_i(counter_value_r),
      .fast_pwm_i(fast_pwm),
      .mode_msb_i(mode_msb_r),
      .block_i(block_r),
      .period_end_i(period_end),
      .select_i(select_a_r),
      .force_i(force_a),
      .cmp_wr_i(wr_cmp_a),
      .cmp_wdata_i(wbyte),
      .cmp_buf_o(cmp_buf_a),
      .cmp_act_o(cmp_act_a),
      .match_o(match_a),
      .state_o(output_a_o)
   );

   // R18 no toggle on channel b
   tcw_channel #(
      .PWM_TOGGLE(1'b0)
   ) u_chan_b (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .tick_i(tick),
      .count_i(counter_value_r),
      .fast_pwm_i(fast_pwm),
      .mode_msb_i(mode_msb_r),
      .block_i(block_r),
      .period_end_i(period_end),
      .select_i(select_b_r),
      .force_i(force_b),
      .cmp_wr_i(wr_cmp_b),
      .cmp_wdata_i(wbyte),
      .cmp_buf_o(cmp_buf_b),
      .cmp_act_o(cmp_act_b),
      .match_o(match_b),
      .state_o(output_b_o)
   );

   // ==========================================================
   // pin override
   // R05 value from the state, direction from the port
   assign pin_a_o = (select_a_r != TCW_SEL_OFF) ? output_a_o : port_value_a_i;
   assign pin_a_oe_o = pin_direction_bit_a_i;
   assign pin_b_o = (select_b_r != TCW_SEL_OFF) ? output_b_o : port_value_b_i;
   assign pin_b_oe_o = pin_direction_bit_b_i;

endmodule : tcw_timer8

`default_nettype wire
